//--- logic/ddr3_cmd_pkg.sv
// shared constants and types of the command link
`default_nettype none
package ddr3_cmd_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 13;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int BANKS = 8;
  localparam int COL_W = 3;
  localparam int CNT_W = 4;
  localparam int BURST_LONG = 8;
  localparam int BURST_CHOP = 4;
  localparam int AP_BIT = 10;
  localparam int CHOP_BIT = 12;
  localparam int CK_HALF = 4;
  // ras, cas, we levels
  localparam logic [2:0] PIN_ACTIVATE = 3'h3;
  localparam logic [2:0] PIN_PRECHARGE = 3'h2;
  localparam logic [2:0] PIN_WRITE = 3'h4;
  localparam logic [2:0] PIN_READ = 3'h5;
  localparam logic [2:0] PIN_MRS = 3'h0;
  localparam logic [2:0] PIN_REFRESH = 3'h1;
  localparam logic [2:0] PIN_NOP = 3'h7;
  localparam logic [2:0] PIN_ZQ = 3'h6;
  // mode register selection and fields
  localparam logic [2:0] MR_BURST = 3'h0;
  localparam logic [2:0] MR_TERM1 = 3'h1;
  localparam logic [2:0] MR_TERM2 = 3'h2;
  localparam int BL_LO = 0;
  localparam int BL_HI = 1;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int RTT1_B0 = 2;
  localparam int RTT1_B1 = 6;
  localparam int RTT1_B2 = 9;
  localparam int RTT2_LO = 9;
  localparam int RTT2_HI = 10;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_DESELECT = 4'h1,
    CMD_ACTIVATE = 4'h2,
    CMD_PRECHARGE = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_READ = 4'h5,
    CMD_MRS = 4'h6,
    CMD_REFRESH = 4'h7,
    CMD_ZQ = 4'h8,
    CMD_SR_ENTRY = 4'h9,
    CMD_PD_ENTRY = 4'hA,
    CMD_WAKE = 4'hB,
    CMD_ILLEGAL = 4'hC
  } cmd_t;
  typedef enum logic [2:0] {
    PWR_ON = 3'h1,
    PWR_DOWN = 3'h2,
    PWR_SELF = 3'h4
  } power_t;
endpackage
`default_nettype wire

//--- logic/ddr3_link_if.sv
// pins between memory controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface ddr3_link_if;
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic reset_n;
  logic lower_byte_mask;
  logic upper_byte_mask;
  logic [ddr3_cmd_pkg::BANK_W-1:0] ba;
  logic [ddr3_cmd_pkg::ADDR_W-1:0] addr;
  logic [ddr3_cmd_pkg::DQ_W-1:0] ctl_dq_out;
  logic ctl_dq_oe_n;
  logic ctl_dqs_out;
  logic ctl_dqs_oe_n;
  logic [ddr3_cmd_pkg::DQ_W-1:0] dev_dq_out;
  logic dev_dq_oe_n;
  logic dev_dqs_out;
  logic dev_dqs_oe_n;
  logic [ddr3_cmd_pkg::DQ_W-1:0] dq;
  logic dqs;
  // --------------------------------
  // wire resolution
  // --------------------------------
  assign dq = !ctl_dq_oe_n ? ctl_dq_out : (!dev_dq_oe_n ? dev_dq_out : '0);
  assign dqs = !ctl_dqs_oe_n ? ctl_dqs_out : (!dev_dqs_oe_n ? dev_dqs_out : 1'b0);
  modport controller (
    output ck, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, lower_byte_mask, upper_byte_mask, ba, addr,
    output ctl_dq_out, ctl_dq_oe_n, ctl_dqs_out, ctl_dqs_oe_n,
    input dq, dqs
  );
  modport device (
    input ck, cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, lower_byte_mask, upper_byte_mask, ba, addr,
    output dev_dq_out, dev_dq_oe_n, dev_dqs_out, dev_dqs_oe_n,
    input dq, dqs
  );
endinterface
`default_nettype wire

//--- logic/ddr3_memory_end.sv
// memory device end: command decoder, bank state, data path, termination
// What this block does
// - pin levels decode into the eight commands
// - commands judged on previous and current CKE
// - precharge A10 low one bank, high all
// - write with A10 high closes bank afterwards
// - read with A10 high closes bank afterwards
// - on-the-fly write with A12 low chops four
// - on-the-fly read with A12 high runs eight
// - fixed burst mode ignores A12 entirely
// - controller accesses only opened, activates only idle; neither end checks this, commands act on any bank
// - mode set: bank picks register, address loads
// - self refresh by refresh with CKE falling
// - power-down entry: CKE falls with no-operation
// - power-down exit: CKE rises with no-operation
// - masked write beat is not stored
// - each byte mask guards its own lane
// - data moves on both strobe edges
// - registered ODT enables termination on data lines
// - ODT ignored when both mode registers disable
// - asynchronous reset while reset pin low
`timescale 1ns/1ps
`default_nettype none
module ddr3_memory_end (
  input wire logic clock,
  input wire logic nrst,
  ddr3_link_if.device link,
  output logic cmd_strobe,
  output ddr3_cmd_pkg::cmd_t cmd_code,
  output logic [ddr3_cmd_pkg::BANKS-1:0] bank_open,
  output ddr3_cmd_pkg::power_t power_state,
  output logic term_enable,
  output logic zq_long_start,
  output logic zq_short_start
);
  localparam int SYN_W = 10 + ddr3_cmd_pkg::BANK_W + ddr3_cmd_pkg::ADDR_W + ddr3_cmd_pkg::DQ_W;
  localparam int IDX_W = ddr3_cmd_pkg::BANK_W + ddr3_cmd_pkg::COL_W;

  // --------------------------------
  // functions
  // --------------------------------
  function automatic ddr3_cmd_pkg::cmd_t decode(input logic prev, input logic cur, input logic sel_n,
                                                input logic [2:0] pins);
    decode = ddr3_cmd_pkg::CMD_NOP;
    if (prev && cur)
    begin
      if (sel_n)
        decode = ddr3_cmd_pkg::CMD_DESELECT;
      else
        case (pins)
          ddr3_cmd_pkg::PIN_ACTIVATE: decode = ddr3_cmd_pkg::CMD_ACTIVATE;
          ddr3_cmd_pkg::PIN_PRECHARGE: decode = ddr3_cmd_pkg::CMD_PRECHARGE;
          ddr3_cmd_pkg::PIN_WRITE: decode = ddr3_cmd_pkg::CMD_WRITE;
          ddr3_cmd_pkg::PIN_READ: decode = ddr3_cmd_pkg::CMD_READ;
          ddr3_cmd_pkg::PIN_MRS: decode = ddr3_cmd_pkg::CMD_MRS;
          ddr3_cmd_pkg::PIN_REFRESH: decode = ddr3_cmd_pkg::CMD_REFRESH;
          ddr3_cmd_pkg::PIN_ZQ: decode = ddr3_cmd_pkg::CMD_ZQ;
          default: decode = ddr3_cmd_pkg::CMD_NOP;
        endcase
    end
    else if (prev)
    begin
      if (!sel_n && pins == ddr3_cmd_pkg::PIN_REFRESH)
        decode = ddr3_cmd_pkg::CMD_SR_ENTRY;
      else if (sel_n || pins == ddr3_cmd_pkg::PIN_NOP)
        decode = ddr3_cmd_pkg::CMD_PD_ENTRY;
      else
        decode = ddr3_cmd_pkg::CMD_ILLEGAL;
    end
    else if (cur && (sel_n || pins == ddr3_cmd_pkg::PIN_NOP))
      decode = ddr3_cmd_pkg::CMD_WAKE;
  endfunction

  function automatic logic [ddr3_cmd_pkg::CNT_W-1:0] burst_len(input logic [1:0] mode, input logic chop_n);
    if (mode == ddr3_cmd_pkg::BL_OTF)
      burst_len = chop_n ? ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BURST_LONG)
                         : ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BURST_CHOP);
    else if (mode == ddr3_cmd_pkg::BL_FIXED4)
      burst_len = ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BURST_CHOP);
    else
      burst_len = ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BURST_LONG);
  endfunction

  function automatic logic [IDX_W-1:0] mem_idx(input logic [ddr3_cmd_pkg::BANK_W-1:0] bank,
                                               input logic [ddr3_cmd_pkg::COL_W-1:0] col,
                                               input logic [ddr3_cmd_pkg::CNT_W-1:0] beat);
    mem_idx = {bank, ddr3_cmd_pkg::COL_W'(col + beat[ddr3_cmd_pkg::COL_W-1:0])};
  endfunction

  // --------------------------------
  // reset and pin synchronisers
  // --------------------------------
  logic rst_n;
  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  logic ck_s, cke_s, cs_n_s, ras_s, cas_s, we_s, odt_s, dqs_s;
  logic [ddr3_cmd_pkg::LANES-1:0] mask_s;
  logic [ddr3_cmd_pkg::BANK_W-1:0] ba_s;
  logic [ddr3_cmd_pkg::ADDR_W-1:0] addr_s;
  logic [ddr3_cmd_pkg::DQ_W-1:0] dq_s;
  logic ck_q;
  logic dqs_q;
  logic cke_last;

  assign rst_n = nrst & link.reset_n;
  assign {ck_s, cke_s, cs_n_s, ras_s, cas_s, we_s, odt_s, dqs_s, mask_s, ba_s, addr_s, dq_s} = sync2;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      ck_q <= 1'b0;
      dqs_q <= 1'b0;
    end
    else
    begin
      sync1 <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n, link.odt, link.dqs,
                link.upper_byte_mask, link.lower_byte_mask, link.ba, link.addr, link.dq};
      sync2 <= sync1;
      ck_q <= ck_s;
      dqs_q <= dqs_s;
    end
  end

  // --------------------------------
  // command decode
  // --------------------------------
  logic ck_rise, ck_edge, dqs_edge, live;
  ddr3_cmd_pkg::cmd_t cmd;
  ddr3_cmd_pkg::power_t next_power;
  logic [ddr3_cmd_pkg::ADDR_W-1:0] mode_reg [ddr3_cmd_pkg::BANKS];
  logic [ddr3_cmd_pkg::ADDR_W-1:0] mr_burst, mr_term1, mr_term2;
  logic term_allowed;

  assign ck_rise = ck_s & ~ck_q;
  assign ck_edge = ck_s ^ ck_q;
  assign dqs_edge = dqs_s ^ dqs_q;
  assign cmd = decode(cke_last, cke_s, cs_n_s, {ras_s, cas_s, we_s});
  assign live = ck_rise && power_state == ddr3_cmd_pkg::PWR_ON;
  assign mr_burst = mode_reg[ddr3_cmd_pkg::MR_BURST];
  assign mr_term1 = mode_reg[ddr3_cmd_pkg::MR_TERM1];
  assign mr_term2 = mode_reg[ddr3_cmd_pkg::MR_TERM2];
  assign term_allowed = mr_term1[ddr3_cmd_pkg::RTT1_B0] | mr_term1[ddr3_cmd_pkg::RTT1_B1]
                      | mr_term1[ddr3_cmd_pkg::RTT1_B2]
                      | (|mr_term2[ddr3_cmd_pkg::RTT2_HI:ddr3_cmd_pkg::RTT2_LO]);

  always_comb
  begin
    next_power = power_state;
    case (power_state)
      ddr3_cmd_pkg::PWR_ON:
        if (ck_rise && cmd == ddr3_cmd_pkg::CMD_SR_ENTRY)
          next_power = ddr3_cmd_pkg::PWR_SELF;
        else if (ck_rise && cmd == ddr3_cmd_pkg::CMD_PD_ENTRY)
          next_power = ddr3_cmd_pkg::PWR_DOWN;
      ddr3_cmd_pkg::PWR_DOWN, ddr3_cmd_pkg::PWR_SELF:
        if (ck_rise && cmd == ddr3_cmd_pkg::CMD_WAKE)
          next_power = ddr3_cmd_pkg::PWR_ON;
      default: next_power = ddr3_cmd_pkg::PWR_ON;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_state <= ddr3_cmd_pkg::PWR_ON;
      cke_last <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_code <= ddr3_cmd_pkg::CMD_NOP;
      zq_long_start <= 1'b0;
      zq_short_start <= 1'b0;
      term_enable <= 1'b0;
      for (int i = 0; i < ddr3_cmd_pkg::BANKS; i++)
        mode_reg[i] <= ddr3_cmd_pkg::MR_RESET;
    end
    else
    begin
      power_state <= next_power;
      cmd_strobe <= ck_rise && cmd != ddr3_cmd_pkg::CMD_NOP && cmd != ddr3_cmd_pkg::CMD_DESELECT;
      zq_long_start <= live && cmd == ddr3_cmd_pkg::CMD_ZQ && addr_s[ddr3_cmd_pkg::AP_BIT];
      zq_short_start <= live && cmd == ddr3_cmd_pkg::CMD_ZQ && !addr_s[ddr3_cmd_pkg::AP_BIT];
      if (ck_rise)
      begin
        cke_last <= cke_s;
        cmd_code <= cmd;
        term_enable <= odt_s && term_allowed;
      end
      if (live && cmd == ddr3_cmd_pkg::CMD_MRS)
        mode_reg[ba_s] <= addr_s;
    end
  end

  // --------------------------------
  // bursts and bank state
  // --------------------------------
  logic [ddr3_cmd_pkg::DQ_W-1:0] mem [ddr3_cmd_pkg::BANKS * ddr3_cmd_pkg::BURST_LONG];
  logic wr_active, wr_ap, rd_active, rd_ap;
  logic [ddr3_cmd_pkg::BANK_W-1:0] wr_bank, rd_bank;
  logic [ddr3_cmd_pkg::COL_W-1:0] wr_col, rd_col;
  logic [ddr3_cmd_pkg::CNT_W-1:0] wr_cnt, wr_len, rd_cnt, rd_len, next_wr_cnt;
  logic wr_beat, wr_done, rd_done, rd_beat, start_wr, start_rd;
  logic [ddr3_cmd_pkg::CNT_W-1:0] new_len;

  assign start_wr = live && cmd == ddr3_cmd_pkg::CMD_WRITE;
  assign start_rd = live && cmd == ddr3_cmd_pkg::CMD_READ;
  assign new_len = burst_len(mr_burst[ddr3_cmd_pkg::BL_HI:ddr3_cmd_pkg::BL_LO], addr_s[ddr3_cmd_pkg::CHOP_BIT]);
  assign wr_beat = wr_active && dqs_edge;
  assign next_wr_cnt = wr_cnt + 1'b1;
  assign wr_done = wr_beat && next_wr_cnt == wr_len;
  assign rd_done = rd_active && ck_edge && rd_cnt == rd_len;
  assign rd_beat = rd_active && ck_edge && rd_cnt != rd_len;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_active <= 1'b0;
      wr_ap <= 1'b0;
      wr_bank <= '0;
      wr_col <= '0;
      wr_cnt <= '0;
      wr_len <= '0;
    end
    else if (start_wr)
    begin
      wr_active <= 1'b1;
      wr_ap <= addr_s[ddr3_cmd_pkg::AP_BIT];
      wr_bank <= ba_s;
      wr_col <= addr_s[ddr3_cmd_pkg::COL_W-1:0];
      wr_cnt <= '0;
      wr_len <= new_len;
    end
    else if (wr_beat)
    begin
      wr_cnt <= next_wr_cnt;
      wr_active <= !wr_done;
    end
  end

  always_ff @(posedge clock)
  begin
    if (wr_beat)
      for (int l = 0; l < ddr3_cmd_pkg::LANES; l++)
        if (!mask_s[l])
          mem[mem_idx(wr_bank, wr_col, wr_cnt)][l*ddr3_cmd_pkg::LANE_W +: ddr3_cmd_pkg::LANE_W]
            <= dq_s[l*ddr3_cmd_pkg::LANE_W +: ddr3_cmd_pkg::LANE_W];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_active <= 1'b0;
      rd_ap <= 1'b0;
      rd_bank <= '0;
      rd_col <= '0;
      rd_cnt <= '0;
      rd_len <= '0;
      link.dev_dq_out <= '0;
      link.dev_dq_oe_n <= 1'b1;
      link.dev_dqs_out <= 1'b0;
      link.dev_dqs_oe_n <= 1'b1;
    end
    else if (start_rd)
    begin
      rd_active <= 1'b1;
      rd_ap <= addr_s[ddr3_cmd_pkg::AP_BIT];
      rd_bank <= ba_s;
      rd_col <= addr_s[ddr3_cmd_pkg::COL_W-1:0];
      rd_cnt <= '0;
      rd_len <= new_len;
    end
    else if (rd_beat)
    begin
      link.dev_dq_out <= mem[mem_idx(rd_bank, rd_col, rd_cnt)];
      link.dev_dqs_out <= ~link.dev_dqs_out;
      link.dev_dq_oe_n <= 1'b0;
      link.dev_dqs_oe_n <= 1'b0;
      rd_cnt <= rd_cnt + 1'b1;
    end
    else if (rd_done)
    begin
      rd_active <= 1'b0;
      link.dev_dq_oe_n <= 1'b1;
      link.dev_dqs_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bank_open <= '0;
    else
    begin
      if (live && cmd == ddr3_cmd_pkg::CMD_PRECHARGE)
      begin
        if (addr_s[ddr3_cmd_pkg::AP_BIT])
          bank_open <= '0;
        else
          bank_open[ba_s] <= 1'b0;
      end
      if (wr_done && wr_ap)
        bank_open[wr_bank] <= 1'b0;
      if (rd_done && rd_ap)
        bank_open[rd_bank] <= 1'b0;
      // activate last: a set in the same cycle as a close wins
      if (live && cmd == ddr3_cmd_pkg::CMD_ACTIVATE)
        bank_open[ba_s] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- logic/ddr3_controller_end.sv
// memory controller end: clock divider, command issue, write and read bursts
`timescale 1ns/1ps
`default_nettype none
module ddr3_controller_end #(
  parameter int CK_HALF = ddr3_cmd_pkg::CK_HALF
) (
  input wire logic clock,
  input wire logic nrst,
  ddr3_link_if.controller link,
  input wire logic req_valid,
  output logic req_ready,
  input wire ddr3_cmd_pkg::cmd_t req_cmd,
  input wire logic [ddr3_cmd_pkg::BANK_W-1:0] req_bank,
  input wire logic [ddr3_cmd_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_cke,
  input wire logic req_chop,
  input wire logic [ddr3_cmd_pkg::BURST_LONG*ddr3_cmd_pkg::DQ_W-1:0] req_wdata,
  input wire logic [ddr3_cmd_pkg::BURST_LONG*ddr3_cmd_pkg::LANES-1:0] req_wmask,
  input wire logic odt_level,
  input wire logic mem_reset_n,
  output logic [ddr3_cmd_pkg::BURST_LONG*ddr3_cmd_pkg::DQ_W-1:0] rd_data,
  output logic rd_valid
);
  localparam int DQ_W = ddr3_cmd_pkg::DQ_W;
  localparam int LN = ddr3_cmd_pkg::LANES;
  localparam logic [ddr3_cmd_pkg::CNT_W-1:0] HALF_LAST = ddr3_cmd_pkg::CNT_W'(CK_HALF - 1);

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ISSUE = 5'h02,
    S_HOLD = 5'h04,
    S_WRITE = 5'h08,
    S_READ = 5'h10
  } ctl_state_t;

  function automatic logic [3:0] encode(input ddr3_cmd_pkg::cmd_t c);
    case (c)
      ddr3_cmd_pkg::CMD_DESELECT: encode = {1'b1, ddr3_cmd_pkg::PIN_NOP};
      ddr3_cmd_pkg::CMD_ACTIVATE: encode = {1'b0, ddr3_cmd_pkg::PIN_ACTIVATE};
      ddr3_cmd_pkg::CMD_PRECHARGE: encode = {1'b0, ddr3_cmd_pkg::PIN_PRECHARGE};
      ddr3_cmd_pkg::CMD_WRITE: encode = {1'b0, ddr3_cmd_pkg::PIN_WRITE};
      ddr3_cmd_pkg::CMD_READ: encode = {1'b0, ddr3_cmd_pkg::PIN_READ};
      ddr3_cmd_pkg::CMD_MRS: encode = {1'b0, ddr3_cmd_pkg::PIN_MRS};
      ddr3_cmd_pkg::CMD_REFRESH: encode = {1'b0, ddr3_cmd_pkg::PIN_REFRESH};
      ddr3_cmd_pkg::CMD_ZQ: encode = {1'b0, ddr3_cmd_pkg::PIN_ZQ};
      default: encode = {1'b0, ddr3_cmd_pkg::PIN_NOP};
    endcase
  endfunction

  // --------------------------------
  // link clock divider and read synchroniser
  // --------------------------------
  ctl_state_t state, next_state;
  logic [ddr3_cmd_pkg::CNT_W-1:0] div_cnt, beat, len;
  logic tick, ck_fall;
  logic [DQ_W:0] sync1, sync2;
  logic dqs_q, dqs_edge;
  ddr3_cmd_pkg::cmd_t cmd_q;
  logic cke_q;
  logic [ddr3_cmd_pkg::BANK_W-1:0] bank_q;
  logic [ddr3_cmd_pkg::ADDR_W-1:0] addr_q;
  logic [ddr3_cmd_pkg::BURST_LONG*DQ_W-1:0] wdata_q;
  logic [ddr3_cmd_pkg::BURST_LONG*LN-1:0] wmask_q;
  logic last_beat;

  assign tick = div_cnt == HALF_LAST;
  assign ck_fall = tick && link.ck;
  assign dqs_edge = sync2[DQ_W] ^ dqs_q;
  assign req_ready = state == S_IDLE;
  assign last_beat = beat == len;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt <= '0;
      link.ck <= 1'b0;
      sync1 <= '0;
      sync2 <= '0;
      dqs_q <= 1'b0;
      link.odt <= 1'b0;
      link.reset_n <= 1'b0;
    end
    else
    begin
      div_cnt <= tick ? '0 : div_cnt + 1'b1;
      link.ck <= tick ? ~link.ck : link.ck;
      sync1 <= {link.dqs, link.dq};
      sync2 <= sync1;
      dqs_q <= sync2[DQ_W];
      link.odt <= odt_level;
      link.reset_n <= mem_reset_n;
    end
  end

  // --------------------------------
  // command sequencing
  // --------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE: if (req_valid) next_state = S_ISSUE;
      S_ISSUE: if (ck_fall) next_state = S_HOLD;
      S_HOLD:
        if (ck_fall)
        begin
          if (cmd_q == ddr3_cmd_pkg::CMD_WRITE && cke_q)
            next_state = S_WRITE;
          else if (cmd_q == ddr3_cmd_pkg::CMD_READ && cke_q)
            next_state = S_READ;
          else
            next_state = S_IDLE;
        end
      S_WRITE: if (tick && last_beat) next_state = S_IDLE;
      S_READ: if (dqs_edge && beat + 1'b1 == len) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_IDLE;
      cmd_q <= ddr3_cmd_pkg::CMD_NOP;
      cke_q <= 1'b0;
      bank_q <= '0;
      addr_q <= '0;
      wdata_q <= '0;
      wmask_q <= '0;
      len <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == S_IDLE && req_valid)
      begin
        cmd_q <= req_cmd;
        cke_q <= req_cke;
        bank_q <= req_bank;
        addr_q <= req_addr;
        wdata_q <= req_wdata;
        wmask_q <= req_wmask;
        len <= req_chop ? ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BURST_CHOP)
                        : ddr3_cmd_pkg::CNT_W'(ddr3_cmd_pkg::BURST_LONG);
      end
    end
  end

  // pins change on the falling link clock, device samples on rising
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      link.cke <= 1'b0;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b1, ddr3_cmd_pkg::PIN_NOP};
      link.ba <= '0;
      link.addr <= '0;
    end
    else if (state == S_ISSUE && ck_fall)
    begin
      link.cke <= cke_q;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= encode(cmd_q);
      link.ba <= bank_q;
      link.addr <= addr_q;
    end
    else if (state == S_HOLD && ck_fall)
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= {1'b0, ddr3_cmd_pkg::PIN_NOP};
  end

  // --------------------------------
  // data bursts
  // --------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      beat <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
      link.ctl_dq_out <= '0;
      link.ctl_dq_oe_n <= 1'b1;
      link.ctl_dqs_out <= 1'b0;
      link.ctl_dqs_oe_n <= 1'b1;
      {link.upper_byte_mask, link.lower_byte_mask} <= '0;
    end
    else
    begin
      rd_valid <= 1'b0;
      if (state == S_HOLD)
        beat <= '0;
      if (((state == S_HOLD && next_state == S_WRITE) || (state == S_WRITE && tick)) && !last_beat)
      begin
        link.ctl_dq_out <= wdata_q[beat*DQ_W +: DQ_W];
        {link.upper_byte_mask, link.lower_byte_mask} <= wmask_q[beat*LN +: LN];
        link.ctl_dqs_out <= ~link.ctl_dqs_out;
        link.ctl_dq_oe_n <= 1'b0;
        link.ctl_dqs_oe_n <= 1'b0;
        beat <= (state == S_HOLD) ? ddr3_cmd_pkg::CNT_W'(1) : beat + 1'b1;
      end
      else if (state == S_WRITE && tick)
      begin
        link.ctl_dq_oe_n <= 1'b1;
        link.ctl_dqs_oe_n <= 1'b1;
      end
      if (state == S_READ && dqs_edge)
      begin
        rd_data[beat*DQ_W +: DQ_W] <= sync2[DQ_W-1:0];
        beat <= beat + 1'b1;
        rd_valid <= beat + 1'b1 == len;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/ddr3_link_props.sv
// concurrent checks on the command link
`timescale 1ns/1ps
`default_nettype none
module ddr3_link_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic [ddr3_cmd_pkg::ADDR_W-1:0] addr,
  input wire logic ctl_dq_oe_n,
  input wire logic ctl_dqs_out,
  input wire logic ctl_dqs_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic dev_dqs_out,
  input wire logic dev_dqs_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------
  // assertions
  // ----------
  a_ck_half_period: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
    else $error("link clock half period wrong");
  a_cmd_at_fall: assert property ($changed({cs_n, ras_n, cas_n, we_n}) |-> $fell(ck))
    else $error("command pins moved off clock fall");
  a_addr_at_fall: assert property ($changed(addr) |-> $fell(ck))
    else $error("address moved off clock fall");
  a_cke_at_fall: assert property ($changed(cke) |-> $fell(ck))
    else $error("cke moved off clock fall");
  a_single_driver: assert property (ctl_dq_oe_n || dev_dq_oe_n)
    else $error("both ends drive data");
  a_ctl_strobe_moves: assert property (not ((!ctl_dqs_oe_n && $stable(ctl_dqs_out)) [*6]))
    else $error("write strobe stalled");
  a_dev_strobe_moves: assert property (not ((!dev_dqs_oe_n && $stable(dev_dqs_out)) [*6]))
    else $error("read strobe stalled");
  a_reset_release: assert property (!reset_n |=> dev_dq_oe_n && dev_dqs_oe_n)
    else $error("device drives in reset");
  c_write_data: cover property ($fell(ctl_dq_oe_n));
  c_read_data: cover property ($fell(dev_dq_oe_n));
  c_dev_reset: cover property ($fell(reset_n));
endmodule
`default_nettype wire

//--- testbench/ddr3_command_decoder_bench.sv
// self-checking bench of controller and memory ends
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_decoder_bench;
  typedef struct packed {
    logic [3:0] e;
    logic [2:0] b;
    logic [12:0] a;
    logic [7:0] o;
  } row_t;
  logic clock, nrst, req_valid, req_ready, req_cke, req_chop, odt_level, mem_reset_n, rd_valid, k;
  logic cmd_strobe, term_enable, zq_long_start, zq_short_start;
  ddr3_cmd_pkg::cmd_t req_cmd, cmd_code, last_cmd;
  ddr3_cmd_pkg::power_t power_state, pw;
  logic [2:0] req_bank;
  logic [12:0] req_addr;
  logic [127:0] req_wdata, rd_data;
  logic [15:0] req_wmask;
  logic [7:0] bank_open;
  logic [1:0] zq_seen;
  int n_fail, cmp_count, n_rdv;
  row_t w;
  row_t rows [18];
  ddr3_link_if link ();
  ddr3_controller_end i_ddr3_controller_end (.clock, .nrst, .link(link.controller), .req_valid, .req_ready,
    .req_cmd, .req_bank, .req_addr, .req_cke, .req_chop, .req_wdata, .req_wmask, .odt_level, .mem_reset_n,
    .rd_data, .rd_valid);
  ddr3_memory_end i_ddr3_memory_end (.clock, .nrst, .link(link.device), .cmd_strobe, .cmd_code, .bank_open,
    .power_state, .term_enable, .zq_long_start, .zq_short_start);
  ddr3_link_props i_ddr3_link_props (.clock, .nrst, .ck(link.ck), .cke(link.cke), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .reset_n(link.reset_n), .addr(link.addr),
    .ctl_dq_oe_n(link.ctl_dq_oe_n), .ctl_dqs_out(link.ctl_dqs_out), .ctl_dqs_oe_n(link.ctl_dqs_oe_n),
    .dev_dq_oe_n(link.dev_dq_oe_n), .dev_dqs_out(link.dev_dqs_out), .dev_dqs_oe_n(link.dev_dqs_oe_n));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // latch decoded commands and calibration pulses
  always @(posedge clock)
  begin
    if (cmd_strobe)
      last_cmd <= cmd_code;
    if (zq_long_start || zq_short_start)
      zq_seen <= {zq_long_start, zq_short_start};
    if (rd_valid)
      n_rdv <= n_rdv + 1;
  end
  task automatic check(input logic [127:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic issue(input ddr3_cmd_pkg::cmd_t c, input logic [2:0] b, input logic [12:0] a, input logic kk, ch);
    int i;
    req_cmd <= c;
    {req_bank, req_addr, req_cke, req_chop, req_valid} <= {b, a, kk, ch, 1'b1};
    @(posedge clock);
    req_valid <= 1'b0;
    for (i = 0; i < 400; i++)
    begin
      @(negedge clock);
      if (req_ready === 1'b1)
        break;
    end
    if (i == 400)
    begin
      n_fail++;
      final_report();
    end
    repeat (16) @(posedge clock);
  endtask
  // -----------
  // main sequence
  // -----------
  initial
  begin
    {nrst, req_valid, req_cke, req_chop, odt_level, mem_reset_n} = 6'h03;
    {req_bank, req_addr} = '0;
    req_cmd = ddr3_cmd_pkg::CMD_NOP;
    last_cmd = ddr3_cmd_pkg::CMD_NOP;
    zq_seen = 2'h0;
    req_wdata = {8{16'h1111}};
    req_wmask = 16'h0000;
    // rows: expected cmd_t code, bank, address, open banks
    rows = '{'{4'hB,3'h0,13'h0000,8'h00}, '{4'h6,3'h0,13'h0001,8'h00}, '{4'h2,3'h3,13'h0000,8'h08},
      '{4'h2,3'h5,13'h0000,8'h28}, '{4'h4,3'h3,13'h0000,8'h28}, '{4'h5,3'h3,13'h1400,8'h20},
      '{4'h4,3'h5,13'h1400,8'h00}, '{4'h2,3'h6,13'h0000,8'h40}, '{4'h2,3'h3,13'h0000,8'h48},
      '{4'h3,3'h6,13'h0000,8'h08}, '{4'h3,3'h0,13'h0400,8'h00}, '{4'h7,3'h0,13'h0000,8'h00},
      '{4'h8,3'h0,13'h0400,8'h00}, '{4'h8,3'h7,13'h0000,8'h00}, '{4'h9,3'h0,13'h0000,8'h00},
      '{4'hB,3'h0,13'h0000,8'h00}, '{4'hA,3'h0,13'h0000,8'h00}, '{4'hB,3'h0,13'h0000,8'h00}};
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    check(power_state, ddr3_cmd_pkg::PWR_ON);
    $display("test reset done");
    foreach (rows[r])
    begin
      w = rows[r];
      k = w.e != 4'h9 && w.e != 4'hA;
      pw = w.e == 4'h9 ? ddr3_cmd_pkg::PWR_SELF : (k ? ddr3_cmd_pkg::PWR_ON : ddr3_cmd_pkg::PWR_DOWN);
      issue(ddr3_cmd_pkg::cmd_t'(w.e == 4'h9 ? 4'h7 : (k && w.e != 4'hB ? w.e : 4'h0)), w.b, w.a, k, !w.a[12]);
      check(last_cmd, w.e);
      check(bank_open, w.o);
      check(power_state, pw);
      if (w.e == 4'h8)
        check(zq_seen, {w.a[10], !w.a[10]});
      $display("test %0d done", r);
    end
    check(term_enable, 1'b0);
    issue(ddr3_cmd_pkg::CMD_MRS, 3'h1, 13'h0004, 1'b1, 1'b0);
    check(term_enable, 1'b1);
    odt_level <= 1'b0;
    issue(ddr3_cmd_pkg::CMD_MRS, 3'h0, 13'h0002, 1'b1, 1'b0);
    check(term_enable, 1'b0);
    issue(ddr3_cmd_pkg::CMD_ACTIVATE, 3'h3, 13'h0000, 1'b1, 1'b0);
    req_wdata <= {8{16'h2C2C}};
    req_wmask <= 16'h0024;
    issue(ddr3_cmd_pkg::CMD_WRITE, 3'h3, 13'h1000, 1'b1, 1'b1);
    issue(ddr3_cmd_pkg::CMD_READ, 3'h3, 13'h1000, 1'b1, 1'b1);
    check(rd_data[63:0], {16'h2C2C, 16'h112C, 16'h2C11, 16'h2C2C});
    $display("test masked write done");
    mem_reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    check(bank_open, 8'h00);
    mem_reset_n <= 1'b1;
    issue(ddr3_cmd_pkg::CMD_NOP, 3'h0, 13'h0000, 1'b1, 1'b0);
    issue(ddr3_cmd_pkg::CMD_ACTIVATE, 3'h2, 13'h0000, 1'b1, 1'b0);
    check(bank_open, 8'h04);
    issue(ddr3_cmd_pkg::CMD_READ, 3'h2, 13'h0400, 1'b1, 1'b0);
    check(bank_open, 8'h00);
    check(n_rdv, 3);
    $display("test device reset done");
    final_report();
  end
endmodule
`default_nettype wire
